// ==== hdl/pmss_top.sv ====
// Power mode and supply supervisor: APB registers, mode sequencing,
// wakeup gating and supervisor handling. Runs in the always-on domain.
// Assumes all inputs synchronous to pclk and analog levels settled.
//
// Notes on behaviour
// - Chip reset follows power-on supervisor level
// - Brownout detector starts disabled until enabled
// - Brownout reset or interrupt; separate thresholds
// - Supply below falling threshold: interrupt or reset
// - Brownout reset ends above rising threshold
// - Three domains switched per power mode
// - Active: all powered, per-module clock gating
// - Sleep: SoC power or clock gated
// - Sleep woken by any enabled source
// - Independent watchdog also wakes from sleep
// - Inter-processor message wakes a sleeping CPU
// - Brownout, power-down interrupts wake both modes
// - Deep sleep: only always-on stays powered
// - Deep sleep woken by always-on events only
// - Wake pins act on edges
// - Leaving deep sleep runs full boot
// - Reset sources reach their own domains
`timescale 1ns/1ns
`default_nettype none
module pmss_top #(
	parameter int N_PINS = 2
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Supply supervisors
	input wire pmss_pkg::pmss_sup_t sup,
	output logic bod_enable,
	output logic [pmss_pkg::THR_W-1:0] bod_fall_sel,
	output logic [pmss_pkg::THR_W-1:0] bod_rise_sel,
	output logic bod_irq,
	// Wakeup sources and reset requests
	input wire logic [pmss_pkg::N_SLEEP_SRC-1:0] sleep_wake_irq,
	input wire logic always_on_timer_irq,
	input wire logic rtc_irq,
	input wire logic [N_PINS-1:0] wake_pin,
	input wire logic chip_en_pd_irq,
	input wire logic wdg_reset_req,
	// Domain controls
	output pmss_pkg::pmss_dom_t dom,
	output logic [pmss_pkg::MOD_W-1:0] mod_clk_gate,
	output logic [pmss_pkg::ANA_W-1:0] ana_pd,
	output pmss_pkg::pmss_mode_t mode,
	// Resets
	output logic chip_rst_n,
	output logic sys_rst_n,
	output logic always_on_timer_rst_n
);
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] wake_en;
		logic [31:0] gate;
		logic bod_flag;
		logic pd_flag;
		logic bor_act;
		logic [pmss_pkg::N_WAKE-1:0] cause;
		pmss_pkg::pmss_mode_t mode;
		logic rst_pulse;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		pmss_pkg::pmss_dom_t dom;
		logic [pmss_pkg::MOD_W-1:0] clk_gate;
		logic [pmss_pkg::ANA_W-1:0] ana_pd;
	} pmss_top_st_t;

	pmss_top_st_t s_reg;
	pmss_top_st_t s_next;
	logic pin_hit;
	logic commit;
	logic wr;
	logic bod_evt;
	logic bor_evt;
	logic [pmss_pkg::N_WAKE-1:0] wake_now;
	logic [pmss_pkg::N_WAKE-1:0] wake_ok;

	// --------------------------------------------------
	// Helpers
	// --------------------------------------------------
	function automatic logic pmss_is_reg(input logic [7:0] a, input logic [7:0] off);
		pmss_is_reg = (a == off);
	endfunction

	function automatic logic pmss_mapped(input logic [7:0] a);
		pmss_mapped = pmss_is_reg(a, pmss_pkg::OFF_CTRL) |
			pmss_is_reg(a, pmss_pkg::OFF_WAKE_EN) |
			pmss_is_reg(a, pmss_pkg::OFF_STATUS) |
			pmss_is_reg(a, pmss_pkg::OFF_GATE);
	endfunction

	// --------------------------------------------------
	// Submodules
	// --------------------------------------------------
	pmss_wake_edge #(
		.N(N_PINS)
	) u_edge (
		.pclk(pclk),
		.presetn(presetn),
		.pins(wake_pin),
		.hit(pin_hit)
	);

	// Watchdog and software reset share the stretched system reset
	pmss_reset_ctl u_rst (
		.pclk(pclk),
		.presetn(presetn),
		.por_ok(sup.por_ok),
		.chip_en(sup.chip_en),
		.bor_hold(s_reg.bor_act),
		.sys_req(s_reg.rst_pulse | wdg_reset_req),
		.chip_rst_n(chip_rst_n),
		.sys_rst_n(sys_rst_n),
		.always_on_timer_rst_n(always_on_timer_rst_n)
	);

	// --------------------------------------------------
	// Event decode
	// --------------------------------------------------
	// Detector acts only once enabled; mode bit picks the reaction
	assign bod_evt = s_reg.ctrl[pmss_pkg::CTRL_BOD_EN] &
		!s_reg.ctrl[pmss_pkg::CTRL_BOD_RST] & sup.bod_below_fall;
	assign bor_evt = s_reg.ctrl[pmss_pkg::CTRL_BOD_EN] &
		s_reg.ctrl[pmss_pkg::CTRL_BOD_RST] & sup.bod_below_fall;
	// Independent watchdog and message lines are ordinary sleep sources
	assign wake_now = {chip_en_pd_irq, bod_evt, rtc_irq, pin_hit,
		always_on_timer_irq, sleep_wake_irq};
	// Brownout and power-down always wake; deep sleep masks peripherals
	assign wake_ok = wake_now & {2'b11, s_reg.wake_en[pmss_pkg::WK_RTC:0]} &
		((s_reg.mode == pmss_pkg::PM_DEEP) ? pmss_pkg::DEEP_MASK : '1);

	// Bus strobes: data settles one cycle, commit at pready edge
	assign commit = psel & penable & s_reg.pready;
	assign wr = commit & pwrite;

	// --------------------------------------------------
	// Next state
	// --------------------------------------------------
	always_comb begin
		logic st_wr;
		st_wr = wr & pmss_is_reg(paddr, pmss_pkg::OFF_STATUS);
		s_next = s_reg;
		s_next.rst_pulse = 1'b0;

		// APB access phase: one wait state, then data and pready
		if (commit) begin
			s_next.pready = 1'b0;
			s_next.pslverr = 1'b0;
		end else if (psel && penable) begin
			s_next.pready = 1'b1;
			s_next.pslverr = !pmss_mapped(paddr);
			s_next.prdata = '0;
			if (pmss_is_reg(paddr, pmss_pkg::OFF_CTRL)) begin
				s_next.prdata = s_reg.ctrl;
			end else if (pmss_is_reg(paddr, pmss_pkg::OFF_WAKE_EN)) begin
				s_next.prdata = s_reg.wake_en;
			end else if (pmss_is_reg(paddr, pmss_pkg::OFF_GATE)) begin
				s_next.prdata = s_reg.gate;
			end else if (pmss_is_reg(paddr, pmss_pkg::OFF_STATUS)) begin
				s_next.prdata[pmss_pkg::ST_BOD_FLAG] = s_reg.bod_flag;
				s_next.prdata[pmss_pkg::ST_PD_FLAG] = s_reg.pd_flag;
				s_next.prdata[pmss_pkg::ST_BOR_ACT] = s_reg.bor_act;
				s_next.prdata[pmss_pkg::ST_MODE_LSB +: 2] = s_reg.mode;
				s_next.prdata[pmss_pkg::ST_CAUSE_LSB +: pmss_pkg::N_WAKE] = s_reg.cause;
			end
		end

		// Register writes; command bits are not stored
		if (wr && pmss_is_reg(paddr, pmss_pkg::OFF_CTRL)) begin
			s_next.ctrl = pwdata & pmss_pkg::CTRL_WMASK;
			s_next.rst_pulse = pwdata[pmss_pkg::CTRL_SW_RST];
		end
		if (wr && pmss_is_reg(paddr, pmss_pkg::OFF_WAKE_EN)) begin
			s_next.wake_en = pwdata;
		end
		if (wr && pmss_is_reg(paddr, pmss_pkg::OFF_GATE)) begin
			s_next.gate = pwdata;
		end

		// Sticky flags: write one clears, a new event wins
		s_next.bod_flag = (s_reg.bod_flag & !(st_wr & pwdata[pmss_pkg::ST_BOD_FLAG])) |
			bod_evt;
		s_next.pd_flag = (s_reg.pd_flag & !(st_wr & pwdata[pmss_pkg::ST_PD_FLAG])) |
			chip_en_pd_irq;
		if (st_wr && pwdata[pmss_pkg::ST_CAUSE_LSB]) begin
			s_next.cause = '0;
		end

		// Brownout reset: set below falling, released above rising
		if (bor_evt) begin
			s_next.bor_act = 1'b1;
		end else if (sup.bod_above_rise) begin
			s_next.bor_act = 1'b0;
		end

		// Mode sequencing
		unique case (s_reg.mode)
			pmss_pkg::PM_ACTIVE: begin
				if (wr && pmss_is_reg(paddr, pmss_pkg::OFF_CTRL)) begin
					if (pwdata[pmss_pkg::CTRL_DEEP_REQ]) begin
						s_next.mode = pmss_pkg::PM_DEEP;
					end else if (pwdata[pmss_pkg::CTRL_SLEEP_REQ]) begin
						s_next.mode = pmss_pkg::PM_SLEEP;
					end
				end
			end
			pmss_pkg::PM_SLEEP: begin
				if (|wake_ok) begin
					s_next.mode = pmss_pkg::PM_ACTIVE;
					s_next.cause = s_reg.cause | wake_ok;
				end
			end
			pmss_pkg::PM_DEEP: begin
				if (|wake_ok) begin
					s_next.mode = pmss_pkg::PM_ACTIVE;
					s_next.cause = s_reg.cause | wake_ok;
					s_next.rst_pulse = 1'b1;
				end
			end
			default: begin
				s_next.mode = pmss_pkg::PM_ACTIVE;
			end
		endcase

		// Domain controls follow the coming mode
		s_next.dom.aon_pwr_en = 1'b1;
		s_next.ana_pd = s_next.gate[pmss_pkg::GATE_ANA_LSB +: pmss_pkg::ANA_W];
		unique case (s_next.mode)
			pmss_pkg::PM_SLEEP: begin
				s_next.dom.system_on_domain_pwr_en = 1'b1;
				s_next.dom.soc_pwr_en = !s_next.ctrl[pmss_pkg::CTRL_SLEEP_PG];
				s_next.dom.soc_clk_en = 1'b0;
				s_next.dom.cpu_clk_en = 1'b0;
				s_next.clk_gate = '1;
			end
			pmss_pkg::PM_DEEP: begin
				s_next.dom.system_on_domain_pwr_en = 1'b0;
				s_next.dom.soc_pwr_en = 1'b0;
				s_next.dom.soc_clk_en = 1'b0;
				s_next.dom.cpu_clk_en = 1'b0;
				s_next.clk_gate = '1;
				s_next.ana_pd = '1;
			end
			default: begin
				s_next.dom.system_on_domain_pwr_en = 1'b1;
				s_next.dom.soc_pwr_en = 1'b1;
				s_next.dom.soc_clk_en = 1'b1;
				s_next.dom.cpu_clk_en = 1'b1;
				s_next.clk_gate = s_next.gate[pmss_pkg::MOD_W-1:0];
			end
		endcase
	end

	// --------------------------------------------------
	// State register
	// --------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.ctrl <= pmss_pkg::CTRL_RST;
			s_reg.wake_en <= pmss_pkg::WAKE_EN_RST;
			s_reg.gate <= pmss_pkg::GATE_RST;
			s_reg.dom <= '1;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from state; thresholds go to the analog block
	assign pready = s_reg.pready;
	assign prdata = s_reg.prdata;
	assign pslverr = s_reg.pslverr;
	assign bod_enable = s_reg.ctrl[pmss_pkg::CTRL_BOD_EN];
	assign bod_fall_sel = s_reg.ctrl[pmss_pkg::CTRL_FALL_LSB +: pmss_pkg::THR_W];
	assign bod_rise_sel = s_reg.ctrl[pmss_pkg::CTRL_RISE_LSB +: pmss_pkg::THR_W];
	assign bod_irq = s_reg.bod_flag;
	assign dom = s_reg.dom;
	assign mod_clk_gate = s_reg.clk_gate;
	assign ana_pd = s_reg.ana_pd;
	assign mode = s_reg.mode;

	// --------------------------------------------------
	// Checks
	// --------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_por_hold_chip: assert property (
		!sup.por_ok |=> !chip_rst_n ##1 !sys_rst_n)
		else $error("chip reset not held under power-on level");
	chk_bod_off_quiet: assert property (
		!bod_enable |=> !$rose(bod_irq) && !$rose(s_reg.bor_act))
		else $error("disabled brownout detector acted");
	chk_bod_irq_mode: assert property (
		bod_enable && !s_reg.ctrl[pmss_pkg::CTRL_BOD_RST] && sup.bod_below_fall
		|=> bod_irq && !$rose(s_reg.bor_act))
		else $error("brownout interrupt not raised");
	chk_bor_reset_mode: assert property (
		bod_enable && s_reg.ctrl[pmss_pkg::CTRL_BOD_RST] && sup.bod_below_fall
		|=> s_reg.bor_act ##1 !sys_rst_n)
		else $error("brownout reset not raised");
	chk_bor_release: assert property (
		s_reg.bor_act && !bor_evt && sup.bod_above_rise |=> !s_reg.bor_act)
		else $error("brownout reset not released above rising level");
	chk_irq_sticky: assert property (
		bod_irq && !(wr && pmss_is_reg(paddr, pmss_pkg::OFF_STATUS)) |=> bod_irq)
		else $error("brownout interrupt dropped without clear");
	chk_sleep_soc_gate: assert property (
		mode == pmss_pkg::PM_SLEEP |-> dom.system_on_domain_pwr_en && !dom.soc_clk_en &&
		dom.soc_pwr_en == !s_reg.ctrl[pmss_pkg::CTRL_SLEEP_PG])
		else $error("sleep domain controls wrong");
	chk_deep_domains: assert property (
		mode == pmss_pkg::PM_DEEP |-> dom.aon_pwr_en && !dom.system_on_domain_pwr_en &&
		!dom.soc_pwr_en && ana_pd == '1)
		else $error("deep sleep left a domain powered");
	chk_sleep_wake_ipc: assert property (
		mode == pmss_pkg::PM_SLEEP && sleep_wake_irq[pmss_pkg::WK_IPC] &&
		s_reg.wake_en[pmss_pkg::WK_IPC] |=> mode == pmss_pkg::PM_ACTIVE)
		else $error("message did not wake from sleep");
	chk_deep_no_periph: assert property (
		mode == pmss_pkg::PM_DEEP && !(|wake_now[pmss_pkg::WK_PD:pmss_pkg::WK_ALWAYS_ON_TIMER])
		|=> mode == pmss_pkg::PM_DEEP)
		else $error("peripheral woke deep sleep");
	chk_deep_boot: assert property (
		mode == pmss_pkg::PM_DEEP ##1 mode == pmss_pkg::PM_ACTIVE |=> !sys_rst_n [*2])
		else $error("no boot reset after deep sleep");
	chk_active_gates: assert property (
		mode == pmss_pkg::PM_ACTIVE |-> mod_clk_gate == s_reg.gate[pmss_pkg::MOD_W-1:0])
		else $error("active clock gates differ from register");

	cov_sleep_wake: cover property (
		mode == pmss_pkg::PM_SLEEP ##1 mode == pmss_pkg::PM_ACTIVE);
	cov_deep_wake: cover property (
		mode == pmss_pkg::PM_DEEP ##1 mode == pmss_pkg::PM_ACTIVE);
	cov_bor_cycle: cover property (
		$rose(s_reg.bor_act) ##[1:50] $fell(s_reg.bor_act));
	cov_pin_wake: cover property (
		mode == pmss_pkg::PM_DEEP && pin_hit && s_reg.wake_en[pmss_pkg::WK_PIN]);
endmodule
`default_nettype wire

// ==== include/pmss_pkg.sv ====
// Constants and carrier types for the power mode and supply supervisor.
// Assumes one 100 MHz APB clock and register offsets on word boundaries.
package pmss_pkg;
	// --------------------------------------------------
	// Register offsets
	// --------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_WAKE_EN = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_GATE = 8'h0C;

	// --------------------------------------------------
	// Control field positions
	// --------------------------------------------------
	localparam int CTRL_BOD_EN = 0;
	localparam int CTRL_BOD_RST = 1;
	localparam int CTRL_FALL_LSB = 4;
	localparam int CTRL_RISE_LSB = 8;
	localparam int CTRL_SLEEP_PG = 12;
	localparam int CTRL_SLEEP_REQ = 16;
	localparam int CTRL_DEEP_REQ = 17;
	localparam int CTRL_SW_RST = 18;
	localparam int THR_W = 3;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_1773;
	localparam logic [31:0] CTRL_RST = 32'h0000_0100;

	// --------------------------------------------------
	// Status and wake field positions
	// --------------------------------------------------
	localparam int ST_BOD_FLAG = 0;
	localparam int ST_PD_FLAG = 1;
	localparam int ST_BOR_ACT = 2;
	localparam int ST_MODE_LSB = 4;
	localparam int ST_CAUSE_LSB = 8;
	localparam int N_SLEEP_SRC = 14;
	localparam int WK_INDEP_WDG = 12;
	localparam int WK_IPC = 13;
	localparam int WK_ALWAYS_ON_TIMER = 14;
	localparam int WK_PIN = 15;
	localparam int WK_RTC = 16;
	localparam int WK_BOD = 17;
	localparam int WK_PD = 18;
	localparam int N_WAKE = 19;
	localparam logic [18:0] DEEP_MASK = 19'h7_C000;
	localparam logic [31:0] WAKE_EN_RST = 32'h0000_0000;

	// --------------------------------------------------
	// Gate register layout and reset timing
	// --------------------------------------------------
	localparam int MOD_W = 16;
	localparam int ANA_W = 8;
	localparam int GATE_ANA_LSB = 16;
	localparam logic [31:0] GATE_RST = 32'h0000_0000;
	localparam int RST_CNT_W = 5;
	localparam logic [4:0] RST_HOLD_CYC = 5'h10;

	// --------------------------------------------------
	// Types
	// --------------------------------------------------
	typedef enum logic [1:0] {
		PM_ACTIVE = 2'b00,
		PM_SLEEP = 2'b01,
		PM_DEEP = 2'b10
	} pmss_mode_t;

	typedef struct packed {
		logic por_ok;
		logic chip_en;
		logic bod_below_fall;
		logic bod_above_rise;
	} pmss_sup_t;

	typedef struct packed {
		logic aon_pwr_en;
		logic system_on_domain_pwr_en;
		logic soc_pwr_en;
		logic soc_clk_en;
		logic cpu_clk_en;
	} pmss_dom_t;
endpackage

// ==== hdl/pmss_wake_edge.sv ====
// Edge detector for the always-on wake pins.
// Assumes pins are already synchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
module pmss_wake_edge #(
	parameter int N = 2
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins and result
	input wire logic [N-1:0] pins,
	output logic hit
);
	typedef struct packed {
		logic armed;
		logic [N-1:0] prev;
		logic hit;
	} pmss_edge_st_t;

	pmss_edge_st_t s_reg;
	pmss_edge_st_t s_next;
	logic [N-1:0] edge_pin;

	// Per-pin change, either direction
	for (genvar i = 0; i < N; i++) begin : g_edge
		assign edge_pin[i] = pins[i] ^ s_reg.prev[i];
	end

	// Not armed until one sample is held, so a pulled-up pin is no edge
	always_comb begin
		s_next = s_reg;
		s_next.armed = 1'b1;
		s_next.prev = pins;
		s_next.hit = s_reg.armed & (|edge_pin);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign hit = s_reg.hit;
endmodule
`default_nettype wire

// ==== hdl/pmss_reset_ctl.sv ====
// Chip-wide and system reset generation.
// Assumes supervisor levels and reset requests are synchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
module pmss_reset_ctl (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Causes
	input wire logic por_ok,
	input wire logic chip_en,
	input wire logic bor_hold,
	input wire logic sys_req,
	// Resets out
	output logic chip_rst_n,
	output logic sys_rst_n,
	output logic always_on_timer_rst_n
);
	typedef struct packed {
		logic chip_n;
		logic sys_n;
		logic [pmss_pkg::RST_CNT_W-1:0] cnt;
	} pmss_rst_st_t;

	pmss_rst_st_t s_reg;
	pmss_rst_st_t s_next;

	// Whole chip follows supervisor and enable pin; system also stretched
	always_comb begin
		s_next = s_reg;
		s_next.chip_n = por_ok & chip_en;
		if (!s_next.chip_n || sys_req) begin
			s_next.cnt = pmss_pkg::RST_HOLD_CYC;
		end else if (s_reg.cnt != '0) begin
			s_next.cnt = s_reg.cnt - 1'b1;
		end
		s_next.sys_n = s_next.chip_n & !bor_hold & (s_next.cnt == '0);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '{chip_n: 1'b0, sys_n: 1'b0, cnt: pmss_pkg::RST_HOLD_CYC};
		end else begin
			s_reg <= s_next;
		end
	end

	// Always-on timer shares the system reset
	assign chip_rst_n = s_reg.chip_n;
	assign sys_rst_n = s_reg.sys_n;
	assign always_on_timer_rst_n = s_reg.sys_n;
endmodule
`default_nettype wire

// ==== verif/pmss_supply_model.sv ====
// Behavioural model of the supply supervisors in front of the block.
// Assumes the bench moves the supply level code at pclk edges.
`timescale 1ns/1ns
`default_nettype none
module pmss_supply_model (
	// Stimulus from the bench
	input wire logic [2:0] level,
	input wire logic chip_en,
	// Threshold selects from the block
	input wire logic [2:0] fall_sel,
	input wire logic [2:0] rise_sel,
	// Supervisor levels
	output var pmss_pkg::pmss_sup_t sup
);
	// --------------------------------------------------
	// Comparators
	// --------------------------------------------------
	// Code 0 sits below power-on; the comparators keep reporting
	// while the detector is disabled, so gating is left to the block
	always_comb begin
		sup.por_ok = (level != 3'h0);
		sup.chip_en = chip_en;
		sup.bod_below_fall = (level < fall_sel);
		sup.bod_above_rise = (level > rise_sel);
	end
endmodule
`default_nettype wire

// ==== verif/pmss_top_bench.sv ====
// Self-checking bench for the power mode and supply supervisor.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module pmss_top_bench;
	// --------------------------------------------------
	// Signals and instances
	// --------------------------------------------------
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic bod_enable, bod_irq, always_on_timer_irq, rtc_irq, chip_en_pd_irq;
	logic wdg_reset_req, chip_rst_n, sys_rst_n, always_on_timer_rst_n, chip_en;
	logic [7:0] paddr, ana_pd;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] bod_fall_sel, bod_rise_sel, level;
	logic [13:0] sleep_wake_irq;
	logic [1:0] wake_pin;
	logic [15:0] mod_clk_gate;
	pmss_pkg::pmss_sup_t sup;
	pmss_pkg::pmss_dom_t dom;
	pmss_pkg::pmss_mode_t mode;
	int n_mismatch, checked, i;
	// Fall 2, rise 5, detector on, interrupt mode; rise kept above fall
	localparam logic [31:0] BASE = 32'h0521;

	pmss_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .sup(sup), .bod_enable(bod_enable),
		.bod_fall_sel(bod_fall_sel), .bod_rise_sel(bod_rise_sel), .bod_irq(bod_irq),
		.sleep_wake_irq(sleep_wake_irq), .always_on_timer_irq(always_on_timer_irq),
		.rtc_irq(rtc_irq), .wake_pin(wake_pin), .chip_en_pd_irq(chip_en_pd_irq),
		.wdg_reset_req(wdg_reset_req), .dom(dom), .mod_clk_gate(mod_clk_gate),
		.ana_pd(ana_pd), .mode(mode), .chip_rst_n(chip_rst_n), .sys_rst_n(sys_rst_n),
		.always_on_timer_rst_n(always_on_timer_rst_n));
	pmss_supply_model sm (.level(level), .chip_en(chip_en), .fall_sel(bod_fall_sel),
		.rise_sel(bod_rise_sel), .sup(sup));

	// --------------------------------------------------
	// Tasks
	// --------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// One APB transfer; held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No cycle count assumed; only the watchdog ends a stuck wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// --------------------------------------------------
	// Clock, watchdog and tests
	// --------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Tests take about 500 cycles; this is far beyond
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		test_done;
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{always_on_timer_irq, rtc_irq, chip_en_pd_irq, wdg_reset_req} = 4'h0;
		sleep_wake_irq = 14'h0;
		wake_pin = 2'h0;
		level = 3'h7;
		chip_en = 1'b1;
		tick(10);
		presetn <= 1'b1;
		tick(5);
		chk(32'({chip_rst_n, sys_rst_n}), 32'h2);
		tick(20);
		chk(32'(sys_rst_n), 32'h1);
		apb(1'b0, pmss_pkg::OFF_CTRL, 32'h0);
		chk(rd, pmss_pkg::CTRL_RST);
		chk(32'(bod_enable), 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		apb(1'b1, pmss_pkg::OFF_GATE, 32'h00ab_1234);
		tick(1);
		chk(32'({ana_pd, mod_clk_gate}), 32'h00ab_1234);
		// Detector off: a dip must do nothing
		apb(1'b1, pmss_pkg::OFF_CTRL, BASE & 32'hfffe);
		level <= 3'h1;
		tick(3);
		chk(32'({bod_irq, sys_rst_n}), 32'h1);
		apb(1'b1, pmss_pkg::OFF_CTRL, BASE);
		tick(3);
		chk(32'({bod_irq, bod_rise_sel, bod_fall_sel}), 32'h6a);
		level <= 3'h7;
		tick(3);
		chk(32'(bod_irq), 32'h1);
		apb(1'b1, pmss_pkg::OFF_STATUS, 32'h1);
		tick(2);
		chk(32'(bod_irq), 32'h0);
		// Reset mode: held until above the rising threshold
		apb(1'b1, pmss_pkg::OFF_CTRL, BASE | 32'h2);
		level <= 3'h1;
		tick(3);
		chk(32'({chip_rst_n, sys_rst_n}), 32'h2);
		apb(1'b0, pmss_pkg::OFF_STATUS, 32'h0);
		chk(32'(rd[2]), 32'h1);
		level <= 3'h5;
		tick(5);
		chk(32'(sys_rst_n), 32'h0);
		level <= 3'h6;
		tick(25);
		chk(32'(sys_rst_n), 32'h1);
		apb(1'b1, pmss_pkg::OFF_CTRL, BASE);
		level <= 3'h7;
		// Software and watchdog resets spare the chip reset
		apb(1'b1, pmss_pkg::OFF_CTRL, BASE | 32'h0004_0000);
		tick(2);
		chk(32'({chip_rst_n, sys_rst_n, always_on_timer_rst_n}), 32'h4);
		tick(20);
		wdg_reset_req <= 1'b1;
		tick(1);
		wdg_reset_req <= 1'b0;
		tick(2);
		chk(32'({chip_rst_n, sys_rst_n, always_on_timer_rst_n}), 32'h4);
		tick(20);
		// Every sleep source wakes; first pass uses power gating
		apb(1'b1, pmss_pkg::OFF_WAKE_EN, 32'h0001_ffff);
		for (i = 0; i < 14; i++) begin
			apb(1'b1, pmss_pkg::OFF_CTRL, BASE | 32'h0001_0000 | (i == 0 ? 32'h1000 : 32'h0));
			// Watchdog reset request must not wake from sleep
			wdg_reset_req <= (i == 12);
			tick(2);
			chk(32'(mode), 32'(pmss_pkg::PM_SLEEP));
			chk(32'(dom), 32'({2'b11, (i != 0), 2'b00}));
			wdg_reset_req <= 1'b0;
			sleep_wake_irq <= 14'(1 << i);
			tick(3);
			chk(32'({dom, mode}), 32'h7c);
			sleep_wake_irq <= 14'h0;
			tick(1);
		end
		// Causes gathered: every sleep source once, no watchdog extra
		apb(1'b0, pmss_pkg::OFF_STATUS, 32'h0);
		chk(rd, 32'h003f_ff00);
		// Deep sleep: sleep sources ignored, always-on ones wake
		for (i = 0; i < 5; i++) begin
			apb(1'b1, pmss_pkg::OFF_CTRL, BASE | 32'h0002_0000);
			tick(2);
			chk(32'({dom, ana_pd}), 32'h10ff);
			sleep_wake_irq <= 14'h3fff;
			tick(3);
			chk(32'(mode), 32'(pmss_pkg::PM_DEEP));
			sleep_wake_irq <= 14'h0;
			case (i)
				0: always_on_timer_irq <= 1'b1;
				1: rtc_irq <= 1'b1;
				2: wake_pin <= 2'h2;
				3: chip_en_pd_irq <= 1'b1;
				default: level <= 3'h1;
			endcase
			tick(4);
			chk(32'({mode, sys_rst_n}), 32'h0);
			{always_on_timer_irq, rtc_irq, chip_en_pd_irq} <= 3'h0;
			level <= 3'h7;
			tick(20);
		end
		// Chip enable and power-on reset the whole chip
		chip_en <= 1'b0;
		tick(3);
		chk(32'(chip_rst_n), 32'h0);
		chip_en <= 1'b1;
		level <= 3'h0;
		tick(3);
		chk(32'(chip_rst_n), 32'h0);
		level <= 3'h7;
		tick(3);
		chk(32'(chip_rst_n), 32'h1);
		test_done;
	end
endmodule
`default_nettype wire
